// file: hdl/spi_config_power_mode_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - Writing 1 to bit 7 or 0 of config A resets port and registers; self-clears.
// - Config A bit 6 set shifts every byte least significant bit first.
// - Config A bit 1 is the primary shift-order control paired with bit 6.
// - Address-stepping bits 2 and 5 are read-write; addresses increment per byte.
// - Config B bit 7 set allows only one data byte per frame.
// - Config B bit 1 pulses a datapath reset and clears itself.
// - Power field 00 is normal; 10 stops clocks, link and outputs stay on.
// - Power field 11 stops clocks, holds reset, disables link and outputs.
// - Config registers are global; power register per channel, by pair and device index.
module spi_config_power_mode_regs (
  // Clock and reset
  input  wire logic                            MCLK,
  input  wire logic                            SRST,
  // Serial control port pins
  input  wire logic                            SCLK,
  input  wire logic                            PORT_SELECT_N,
  input  wire logic                            SDIO_IN,
  output logic                                 SDIO_OUT,
  output logic                                 SDIO_OE_N,
  // Pair and device index from the neighbouring registers
  input  wire logic [1:0]                      PAIR_SEL,
  input  wire logic [1:0]                      CHAN_SEL,
  // Datapath controls
  output logic                                 DP_SOFT_RESET,
  output spi_cfg_pkg::chan_ctrl_t [3:0]        CHAN_CTRL
);

  spi_cfg_pkg::spi_pins_t   pin_s1_reg;
  spi_cfg_pkg::spi_pins_t   pin_s2_reg;
  logic                     sclk_d_reg;
  spi_cfg_pkg::port_state_t state_reg;
  logic [3:0]               cnt_reg;
  logic [15:0]              sh_reg;
  logic [14:0]              addr_reg;
  logic                     rw_reg;
  logic [7:0]               tx_reg;
  logic                     sdo_reg;
  logic                     oe_n_reg;
  logic                     wr_reg;
  logic [14:0]              wr_addr_reg;
  logic [7:0]               wr_data_reg;
  logic                     lsb_first_reg;
  logic                     ascend_reg;
  logic                     single_reg;
  logic                     sreset_reg;
  logic                     dp_srst_reg;
  logic [1:0]               pwr_reg [spi_cfg_pkg::CHANNELS];
  spi_cfg_pkg::chan_ctrl_t [3:0] ctrl_reg;
  logic                     rise;
  logic                     fall;
  logic                     cs_active;
  logic                     byte_done;
  logic [15:0]              sh_next;
  logic [3:0]               sel_mask;
  logic                     tx_bit;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  // Channel A,B sit in pair A/B; C,D in pair C/D
  function automatic logic [3:0] chan_mask(input logic [1:0] pair, input logic [1:0] chan);
    chan_mask = {pair[1] & chan[1], pair[1] & chan[0], pair[0] & chan[1], pair[0] & chan[0]};
  endfunction

  // Readback value of an address; first selected channel wins
  function automatic logic [7:0] rd_value(input logic [14:0] a);
    logic [1:0] p;
    p = 2'h0;
    for (int c = spi_cfg_pkg::CHANNELS - 1; c >= 0; c--) begin
      if (sel_mask[c]) begin
        p = pwr_reg[c];
      end
    end
    unique case (a)
      spi_cfg_pkg::ADDR_CFG_A: rd_value = {1'h0, lsb_first_reg, ascend_reg, 2'h0,
                                           ascend_reg, lsb_first_reg, 1'h0};
      spi_cfg_pkg::ADDR_CFG_B: rd_value = {single_reg, 7'h00};
      spi_cfg_pkg::ADDR_PWR:   rd_value = {6'h00, p};
      default:                 rd_value = 8'h00;
    endcase
  endfunction

  // Two-stage synchroniser for the asynchronous pins
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pin_s1_reg <= 3'h2;
      pin_s2_reg <= 3'h2;
      sclk_d_reg <= 1'h0;
    end else begin
      pin_s1_reg <= {SCLK, PORT_SELECT_N, SDIO_IN};
      pin_s2_reg <= pin_s1_reg;
      sclk_d_reg <= pin_s2_reg.sclk;
    end
  end

  // Edge detection and bit assembly in the selected order
  always_comb begin
    rise      = pin_s2_reg.sclk & ~sclk_d_reg;
    fall      = ~pin_s2_reg.sclk & sclk_d_reg;
    cs_active = ~pin_s2_reg.cs_n;
    byte_done = cs_active && (state_reg == spi_cfg_pkg::ST_DATA) && rise
              && (cnt_reg == spi_cfg_pkg::BYTE_LAST);
    sel_mask  = chan_mask(PAIR_SEL, CHAN_SEL);
    tx_bit    = lsb_first_reg ? tx_reg[cnt_reg[2:0]] : tx_reg[3'h7 - cnt_reg[2:0]];
    if (state_reg == spi_cfg_pkg::ST_DATA) begin
      sh_next = lsb_first_reg ? {8'h00, pin_s2_reg.sdi, sh_reg[7:1]}
                              : {8'h00, sh_reg[6:0], pin_s2_reg.sdi};
    end else begin
      sh_next = lsb_first_reg ? {pin_s2_reg.sdi, sh_reg[15:1]}
                              : {sh_reg[14:0], pin_s2_reg.sdi};
    end
  end

  // Frame sequencer: instruction, data bytes, hold
  always_ff @(posedge MCLK) begin
    wr_reg <= 1'h0;
    if (SRST) begin
      state_reg   <= spi_cfg_pkg::ST_IDLE;
      cnt_reg     <= 4'h0;
      sh_reg      <= 16'h0000;
      addr_reg    <= 15'h0000;
      rw_reg      <= 1'h0;
      tx_reg      <= 8'h00;
      wr_addr_reg <= 15'h0000;
      wr_data_reg <= 8'h00;
    end else if (sreset_reg) begin
      state_reg <= spi_cfg_pkg::ST_HOLD;
      cnt_reg   <= 4'h0;
      rw_reg    <= 1'h0;
    end else if (!cs_active) begin
      state_reg <= spi_cfg_pkg::ST_IDLE;
      cnt_reg   <= 4'h0;
    end else begin
      unique case (state_reg)
        spi_cfg_pkg::ST_IDLE, spi_cfg_pkg::ST_INSTR: begin
          state_reg <= spi_cfg_pkg::ST_INSTR;
          if (rise) begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_reg + 4'h1;
            if (cnt_reg == spi_cfg_pkg::INSTR_LAST) begin
              state_reg <= spi_cfg_pkg::ST_DATA;
              cnt_reg   <= 4'h0;
              rw_reg    <= sh_next[15];
              addr_reg  <= sh_next[14:0];
              tx_reg    <= rd_value(sh_next[14:0]);
            end
          end
        end
        spi_cfg_pkg::ST_DATA: begin
          if (rise) begin
            sh_reg  <= sh_next;
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (byte_done) begin
            cnt_reg     <= 4'h0;
            wr_reg      <= ~rw_reg;
            wr_addr_reg <= addr_reg;
            wr_data_reg <= sh_next[7:0];
            addr_reg    <= addr_reg + 15'h0001;
            tx_reg      <= rd_value(addr_reg + 15'h0001);
            if (single_reg) begin
              state_reg <= spi_cfg_pkg::ST_HOLD;
            end
          end
        end
        spi_cfg_pkg::ST_HOLD: begin
          state_reg <= spi_cfg_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // Read data driven on falling clock edges
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sdo_reg  <= 1'h0;
      oe_n_reg <= 1'h1;
    end else begin
      oe_n_reg <= ~(cs_active && rw_reg && (state_reg == spi_cfg_pkg::ST_DATA));
      if (fall && (state_reg == spi_cfg_pkg::ST_DATA) && rw_reg) begin
        sdo_reg <= tx_bit;
      end
    end
  end

  // Configuration and channel power registers
  always_ff @(posedge MCLK) begin
    if (SRST || sreset_reg) begin
      lsb_first_reg <= spi_cfg_pkg::CFG_BIT_RESET;
      ascend_reg    <= spi_cfg_pkg::CFG_BIT_RESET;
      single_reg    <= spi_cfg_pkg::CFG_BIT_RESET;
      for (int c = 0; c < spi_cfg_pkg::CHANNELS; c++) begin
        pwr_reg[c] <= spi_cfg_pkg::PWR_RESET;
      end
    end else if (wr_reg) begin
      if (wr_addr_reg == spi_cfg_pkg::ADDR_CFG_A) begin
        lsb_first_reg <= wr_data_reg[spi_cfg_pkg::CFGA_LSB]
                       | wr_data_reg[spi_cfg_pkg::CFGA_LSB_MIR];
        ascend_reg    <= wr_data_reg[spi_cfg_pkg::CFGA_ASC]
                       | wr_data_reg[spi_cfg_pkg::CFGA_ASC_MIR];
      end
      if (wr_addr_reg == spi_cfg_pkg::ADDR_CFG_B) begin
        single_reg <= wr_data_reg[spi_cfg_pkg::CFGB_SINGLE];
      end
      if (wr_addr_reg == spi_cfg_pkg::ADDR_PWR) begin
        for (int c = 0; c < spi_cfg_pkg::CHANNELS; c++) begin
          if (sel_mask[c]) begin
            pwr_reg[c] <= wr_data_reg[1:0];
          end
        end
      end
    end
  end

  // Self-clearing soft reset strobes
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sreset_reg  <= 1'h0;
      dp_srst_reg <= 1'h0;
    end else begin
      sreset_reg  <= ~sreset_reg && wr_reg && (wr_addr_reg == spi_cfg_pkg::ADDR_CFG_A)
                  && (wr_data_reg[spi_cfg_pkg::CFGA_SRST_HI]
                  | wr_data_reg[spi_cfg_pkg::CFGA_SRST_LO]);
      dp_srst_reg <= ~sreset_reg && wr_reg && (wr_addr_reg == spi_cfg_pkg::ADDR_CFG_B)
                  && wr_data_reg[spi_cfg_pkg::CFGB_DP_SRST];
    end
  end

  // Per-channel power state decode
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ctrl_reg <= '0;
    end else begin
      for (int c = 0; c < spi_cfg_pkg::CHANNELS; c++) begin
        unique case (pwr_reg[c])
          spi_cfg_pkg::PWR_STANDBY: ctrl_reg[c] <= {1'h0, dp_srst_reg, 1'h1, 1'h1};
          spi_cfg_pkg::PWR_DOWN:    ctrl_reg[c] <= {1'h0, 1'h1, 1'h0, 1'h0};
          default:                  ctrl_reg[c] <= {1'h1, dp_srst_reg, 1'h1, 1'h1};
        endcase
      end
    end
  end

  // Outputs
  assign SDIO_OUT      = sdo_reg;
  assign SDIO_OE_N     = oe_n_reg;
  assign DP_SOFT_RESET = dp_srst_reg;
  assign CHAN_CTRL     = ctrl_reg;

  chk_soft_reset_clear: assert property (sreset_reg |=> !sreset_reg && !lsb_first_reg
    && !ascend_reg && !single_reg && (pwr_reg[0] == 2'h0) && (state_reg != spi_cfg_pkg::ST_DATA))
    else $error("soft reset did not clear");
  chk_lsb_order_out: assert property ((fall && rw_reg && (state_reg == spi_cfg_pkg::ST_DATA)
    && lsb_first_reg) |=> sdo_reg == $past(tx_reg[cnt_reg[2:0]]))
    else $error("LSB-first bit order wrong");
  chk_primary_order_bit: assert property ((wr_reg && !sreset_reg
    && (wr_addr_reg == spi_cfg_pkg::ADDR_CFG_A) && wr_data_reg[spi_cfg_pkg::CFGA_LSB])
    |=> lsb_first_reg)
    else $error("primary order bit not applied");
  chk_addr_step: assert property ((byte_done && !sreset_reg) |=>
    addr_reg == $past(addr_reg) + 15'h0001)
    else $error("address did not step");
  chk_single_access_hold: assert property ((byte_done && single_reg && !sreset_reg)
    |=> (state_reg == spi_cfg_pkg::ST_HOLD) ##1 (!wr_reg)[*3])
    else $error("single access not held");
  chk_dp_reset_pulse: assert property ($rose(dp_srst_reg) |=> !dp_srst_reg
    && (ctrl_reg[0].dp_reset == 1'h1))
    else $error("datapath reset pulse wrong");
  chk_standby_state: assert property ((pwr_reg[0] == spi_cfg_pkg::PWR_STANDBY) |=>
    !ctrl_reg[0].clk_en && ctrl_reg[0].link_en && ctrl_reg[0].out_en)
    else $error("standby controls wrong");
  chk_power_down_state: assert property ((pwr_reg[1] == spi_cfg_pkg::PWR_DOWN) |=>
    (ctrl_reg[1] == 4'h4))
    else $error("power-down controls wrong");
  chk_chan_select_wr: assert property ((wr_reg && !sreset_reg && sel_mask[2]
    && (wr_addr_reg == spi_cfg_pkg::ADDR_PWR)) |=> pwr_reg[2] == $past(wr_data_reg[1:0]))
    else $error("selected channel not written");
  chk_reserved_zero: assert property (((state_reg == spi_cfg_pkg::ST_DATA)
    && (addr_reg == spi_cfg_pkg::ADDR_CFG_B)) |-> tx_reg[6:0] == 7'h00)
    else $error("reserved bits not zero");
  chk_mirror_track: assert property (((state_reg == spi_cfg_pkg::ST_DATA)
    && (addr_reg == spi_cfg_pkg::ADDR_CFG_A)) |-> (tx_reg[6] == tx_reg[1])
    && (tx_reg[5] == tx_reg[2]))
    else $error("mirror bits differ");

endmodule

// file: hdl/spi_cfg_pkg.sv
package spi_cfg_pkg;

  // Register offsets on the serial port
  localparam logic [14:0] ADDR_CFG_A = 15'h0000;
  localparam logic [14:0] ADDR_CFG_B = 15'h0001;
  localparam logic [14:0] ADDR_PWR   = 15'h0002;

  // Bit positions of the first configuration register
  localparam int CFGA_SRST_HI = 7;
  localparam int CFGA_LSB_MIR = 6;
  localparam int CFGA_ASC_MIR = 5;
  localparam int CFGA_ASC     = 2;
  localparam int CFGA_LSB     = 1;
  localparam int CFGA_SRST_LO = 0;

  // Bit positions of the second configuration register
  localparam int CFGB_SINGLE  = 7;
  localparam int CFGB_DP_SRST = 1;

  // Reset values
  localparam logic       CFG_BIT_RESET = 1'h0;
  localparam logic [1:0] PWR_RESET     = 2'h0;

  // Channel power field codes
  localparam logic [1:0] PWR_NORMAL  = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h2;
  localparam logic [1:0] PWR_DOWN    = 2'h3;

  // Frame geometry
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST  = 4'h7;
  localparam int         CHANNELS   = 4;

  // Controls handed to one channel
  typedef struct packed {
    logic clk_en;
    logic dp_reset;
    logic link_en;
    logic out_en;
  } chan_ctrl_t;

  // Serial pins sampled together
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } spi_pins_t;

  // Serial port sequencer
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b10,
    ST_HOLD  = 2'b11
  } port_state_t;

endpackage

// file: tb/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic mclk,
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      drv_en,
  output logic      drv_d,
  input  wire logic sdio
);
  logic lsb_first;

  // Idle bus, clock parked low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    drv_en = 1'b0;
    drv_d = 1'b0;
    lsb_first = 1'b0;
  end

  // Data set while low, sampled at the rise, high and low each HALF cycles
  task automatic bit_cyc(input logic d, input logic en, output logic q);
    drv_d <= d;
    drv_en <= en;
    repeat (HALF) @(posedge mclk);
    q = sdio;
    sclk <= 1'b1;
    repeat (HALF) @(posedge mclk);
    sclk <= 1'b0;
  endtask

  // One frame: instruction, then nb bytes taken from wdata upper byte first
  task automatic frame(input logic rd, input logic [14:0] addr, input int nb,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [15:0] ins;
    logic [7:0]  b;
    logic        q;
    ins = {rd, addr};
    rdata = 16'h0000;
    cs_n <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      bit_cyc(lsb_first ? ins[i] : ins[15-i], 1'b1, q);
    end
    for (int k = 0; k < nb; k++) begin
      b = wdata[15-8*k -: 8];
      for (int i = 0; i < 8; i++) begin
        bit_cyc(b[lsb_first ? i : 7-i], !rd, q);
        rdata[(lsb_first ? i : 7-i) + 8 - 8*k] = q;
      end
    end
    repeat (HALF) @(posedge mclk);
    cs_n <= 1'b1;
    drv_en <= 1'b0;
    repeat (4*HALF) @(posedge mclk);
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic                           mclk = 1'b0;
  logic                           srst = 1'b1;
  logic [1:0]                     pair_sel = 2'h1;
  logic [1:0]                     chan_sel = 2'h1;
  logic                           sclk, cs_n, drv_en, drv_d, sdio_out, sdio_oe_n;
  logic                           sdio, last = 1'b0;
  logic                           dp_rst;
  spi_cfg_pkg::chan_ctrl_t [3:0]  ctrl;
  logic [15:0]                    r;
  int                             err_total = 0;
  int                             n_tests = 0;
  int                             dp_cnt = 0;
  logic [3:0]                     pwr_exp [4] = '{4'hB, 4'h3, 4'h4, 4'hB};
  logic [1:0]                     pwr_code [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  logic [7:0]                     srst_code [3] = '{8'h81, 8'h80, 8'h01};

  // Clock, 4 ns period
  always #2 mclk = ~mclk;

  // Wire level: device, then host, else a toggling released line
  assign sdio = !sdio_oe_n ? sdio_out : (drv_en ? drv_d : ~last);
  always @(posedge mclk) last <= sdio;
  always @(posedge mclk) if (dp_rst) dp_cnt++;

  spi_host_model #(.HALF(8)) host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n),
    .drv_en(drv_en), .drv_d(drv_d), .sdio(sdio));

  spi_config_power_mode_regs dut (.MCLK(mclk), .SRST(srst), .SCLK(sclk),
    .PORT_SELECT_N(cs_n), .SDIO_IN(sdio), .SDIO_OUT(sdio_out), .SDIO_OE_N(sdio_oe_n),
    .PAIR_SEL(pair_sel), .CHAN_SEL(chan_sel), .DP_SOFT_RESET(dp_rst), .CHAN_CTRL(ctrl));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Only documented addresses are ever written
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.frame(1'b0, a, 1, {d, 8'h00}, r);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    host.frame(1'b1, a, 1, 16'h0000, r);
    check(r, {exp, 8'h00});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (80000) @(posedge mclk);
    err_total++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    repeat (3) @(posedge mclk);
    // Reset values
    rd_chk(spi_cfg_pkg::ADDR_CFG_A, 8'h00);
    rd_chk(spi_cfg_pkg::ADDR_CFG_B, 8'h00);
    rd_chk(spi_cfg_pkg::ADDR_PWR, 8'h00);
    check({12'h000, ctrl[3]}, 16'h000B);
    // Stepping bits, mirrors and reserved bits
    wr(spi_cfg_pkg::ADDR_CFG_A, 8'h24);
    rd_chk(spi_cfg_pkg::ADDR_CFG_A, 8'h24);
    wr(spi_cfg_pkg::ADDR_CFG_A, 8'h04);
    rd_chk(spi_cfg_pkg::ADDR_CFG_A, 8'h24);
    wr(spi_cfg_pkg::ADDR_CFG_A, 8'h18);
    rd_chk(spi_cfg_pkg::ADDR_CFG_A, 8'h00);
    // Datapath reset strobe self-clears, reserved bits dropped
    wr(spi_cfg_pkg::ADDR_CFG_B, 8'h7F);
    rd_chk(spi_cfg_pkg::ADDR_CFG_B, 8'h00);
    check(16'(dp_cnt), 16'h0001);
    // Streaming write across two registers, then streaming read
    host.frame(1'b0, spi_cfg_pkg::ADDR_CFG_B, 2, 16'h0002, r);
    rd_chk(spi_cfg_pkg::ADDR_PWR, 8'h02);
    host.frame(1'b1, spi_cfg_pkg::ADDR_CFG_B, 2, 16'h0000, r);
    check(r, 16'h0002);
    // Single access drops the second byte
    wr(spi_cfg_pkg::ADDR_CFG_B, 8'h80);
    host.frame(1'b0, spi_cfg_pkg::ADDR_CFG_B, 2, 16'h8003, r);
    rd_chk(spi_cfg_pkg::ADDR_PWR, 8'h02);
    wr(spi_cfg_pkg::ADDR_CFG_B, 8'h00);
    // Every power code on channel A with channel B normal, then channel D and all four
    for (int c = 0; c < 4; c++) begin
      wr(spi_cfg_pkg::ADDR_PWR, {6'h00, pwr_code[c]});
      check({8'h00, ctrl[0], ctrl[1]}, {8'h00, pwr_exp[c], 4'hB});
    end
    pair_sel <= 2'h2;
    chan_sel <= 2'h2;
    wr(spi_cfg_pkg::ADDR_PWR, 8'h03);
    check({8'h00, ctrl[3], ctrl[0]}, 16'h004B);
    pair_sel <= 2'h3;
    chan_sel <= 2'h3;
    rd_chk(spi_cfg_pkg::ADDR_PWR, 8'h01);
    wr(spi_cfg_pkg::ADDR_PWR, 8'h00);
    check({ctrl[0], ctrl[1], ctrl[2], ctrl[3]}, 16'hBBBB);
    // Primary shift-order bit alone turns on least significant bit first
    wr(spi_cfg_pkg::ADDR_CFG_A, 8'h02);
    host.lsb_first = 1'b1;
    rd_chk(spi_cfg_pkg::ADDR_CFG_A, 8'h42);
    // Mirror bit alone keeps least significant bit first
    wr(spi_cfg_pkg::ADDR_CFG_A, 8'h40);
    rd_chk(spi_cfg_pkg::ADDR_CFG_A, 8'h42);
    wr(spi_cfg_pkg::ADDR_CFG_A, 8'h00);
    host.lsb_first = 1'b0;
    rd_chk(spi_cfg_pkg::ADDR_CFG_A, 8'h00);
    // Soft reset through either bit clears everything
    for (int s = 0; s < 3; s++) begin
      wr(spi_cfg_pkg::ADDR_PWR, 8'h03);
      wr(spi_cfg_pkg::ADDR_CFG_B, 8'h80);
      wr(spi_cfg_pkg::ADDR_CFG_A, srst_code[s]);
      // Recovery wait, shortened since boot loading is not modelled
      repeat (200) @(posedge mclk);
      rd_chk(spi_cfg_pkg::ADDR_CFG_A, 8'h00);
      rd_chk(spi_cfg_pkg::ADDR_CFG_B, 8'h00);
      rd_chk(spi_cfg_pkg::ADDR_PWR, 8'h00);
      check({12'h000, ctrl[0]}, 16'h000B);
    end
    final_report();
  end
endmodule
